// file: buck_loop_compensator_pwm.sv
// Buck rail loop: error sampling, compensator and two PWM engines
//
// Overview of operation
// - Gain codes 0..3 give 1x,2x,4x,8x, i.e. 8,4,2,1 mV per error step.
// - The error code is signed and clips to -32 below and +31 above range.
// - While saturated the set-point slews toward the sense at 0.156 V/ms.
// - The set-point is a 10-bit reference compared with the sampled sense.
// - The sense is captured once per period at the programmed sample time.
// - Each coefficient bank carries its own front-end gain setting.
// - Bank 0 in ramp/track, bank 1 in regulation, bank 2 at light load.
// - Error passes a nonlinear gain, a second- then a first-order IIR.
// - Four signed limits split the error into regions with own gains.
// - Duty times period gives the threshold compared with the counter.
// - Engines sync to each other or the sync pin and can drive sync out.
// - Ramp restart source: none, engine 1, engine 2 or the sync pin.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "buck_loop_regs.svh"

module buck_loop_compensator_pwm
  import buck_loop_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] sense_pos_in,
  input wire logic [9:0] sense_neg_in,
  input wire logic ext_sync_input,
  output logic gate_drive_a,
  output logic gate_drive_b,
  output logic ext_sync_output
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  function automatic logic signed [15:0] sat16(
    input logic signed [35:0] acc);
    logic signed [35:0] s;
    s = acc >>> `COEF_FRAC;
    if (s > 36'sh00000_7fff)
      return 16'sh7fff;
    else if (s < -36'sh00000_8000)
      return -16'sh8000;
    else
      return s[15:0];
  endfunction

  function automatic coeff_bank_t unpack(input logic [159:0] w);
    coeff_bank_t c;
    c.b0 = w[15:0];
    c.b1 = w[31:16];
    c.b2 = w[47:32];
    c.a1 = w[63:48];
    c.a2 = w[79:64];
    c.b3 = w[95:80];
    c.b4 = w[111:96];
    c.a3 = w[127:112];
    c.front_end_gain_sel = w[129:128];
    return c;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr_en;
  logic in_bank;
  logic [ADDR_W-1:0] bank_off;
  logic [1:0] bank_idx;
  logic [2:0] word_idx;
  logic bank_hit;
  logic hit;

  assign wr_en = psel && penable && pwrite;
  assign in_bank = (paddr >= ADDR_W'(`OFF_BANK_BASE)) &&
                   (paddr < ADDR_W'(`OFF_BANK_END));
  assign bank_off = paddr - ADDR_W'(`OFF_BANK_BASE);
  assign bank_idx = bank_off[`BANK_SHIFT +: 2];
  assign word_idx = bank_off[4:2];
  assign bank_hit = in_bank && (word_idx < `BANK_WORDS) &&
                    (paddr[1:0] == 2'h0);

  always_comb
  begin
    case (paddr)
      `OFF_CTRL, `OFF_SAMPLE, `OFF_PERIOD, `OFF_SYNC, `OFF_VREF,
      `OFF_LIMITS, `OFF_NLGAIN, `OFF_DUTYB, `OFF_STATUS: hit = 1'b1;
      default: hit = bank_hit;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [15:0] sample_r;
  logic [15:0] period_r;
  logic [3:0] sync_r;
  logic [31:0] limits_r;
  logic [31:0] nlgain_r;
  logic [15:0] duty_b_r;
  logic [31:0] bank_w_r [0:2][0:4];
  logic [31:0] wmerge;

  assign wmerge = merge(prdata, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= 32'h0000_0000;
      sample_r <= `RST_SAMPLE;
      period_r <= `RST_PERIOD;
      sync_r <= 4'h0;
      limits_r <= `RST_LIMITS;
      nlgain_r <= {2'h0, {5{`NLG_UNITY}}};
      duty_b_r <= 16'h0000;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFF_CTRL: ctrl_r <= wmerge;
        `OFF_SAMPLE: sample_r <= wmerge[15:0];
        `OFF_PERIOD: period_r <= wmerge[15:0];
        `OFF_SYNC: sync_r <= wmerge[3:0];
        `OFF_LIMITS: limits_r <= {{2{wmerge[29]}}, wmerge[29:24],
          {2{wmerge[21]}}, wmerge[21:16], {2{wmerge[13]}}, wmerge[13:8],
          {2{wmerge[5]}}, wmerge[5:0]};
        `OFF_NLGAIN: nlgain_r <= wmerge;
        `OFF_DUTYB: duty_b_r <= wmerge[15:0];
        default: ;
      endcase
    end
  end

  // Coefficient banks, gain code kept in word 4 of each bank
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int b = 0; b < 3; b++)
        for (int w = 0; w < 5; w++)
          bank_w_r[b][w] <= 32'h0000_0000;
    end
    else if (wr_en && bank_hit)
      bank_w_r[bank_idx][word_idx] <= (word_idx == 3'h4) ?
        {30'h0, wmerge[1:0]} : wmerge;
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [9:0] pos_s1;
  logic [9:0] pos_s2;
  logic [9:0] neg_s1;
  logic [9:0] neg_s2;
  logic sync_s1;
  logic sync_s2;
  logic sync_s3;
  logic ext_edge;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_s1 <= 10'h000;
      pos_s2 <= 10'h000;
      neg_s1 <= 10'h000;
      neg_s2 <= 10'h000;
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end
    else
    begin
      pos_s1 <= sense_pos_in;
      pos_s2 <= pos_s1;
      neg_s1 <= sense_neg_in;
      neg_s2 <= neg_s1;
      sync_s1 <= ext_sync_input;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end

  assign ext_edge = sync_s2 && !sync_s3;

  // ----------------------------------------
  // Bank select and error converter
  // ----------------------------------------
  logic [1:0] bank_sel;
  coeff_bank_t cb;
  logic [15:0] cnt_a;
  logic sample_pulse;
  logic signed [11:0] diff;
  logic signed [11:0] scaled;
  logic signed [5:0] err_code;
  logic [9:0] vref_r;

  always_comb
  begin
    if (ctrl_r[`CTRL_RAMP])
      bank_sel = `BANK_RAMP;
    else if (ctrl_r[`CTRL_LIGHT])
      bank_sel = `BANK_LIGHT;
    else
      bank_sel = `BANK_REG;
  end

  assign cb = unpack({bank_w_r[bank_sel][4], bank_w_r[bank_sel][3],
                      bank_w_r[bank_sel][2], bank_w_r[bank_sel][1],
                      bank_w_r[bank_sel][0]});

  // One hit per period, as the counter passes the value once
  assign sample_pulse = ctrl_r[`CTRL_EN] && (cnt_a == sample_r);
  assign diff = $signed({2'h0, vref_r}) -
                ($signed({2'h0, pos_s2}) - $signed({2'h0, neg_s2}));
  assign scaled = diff >>> (`GAIN_8X - cb.front_end_gain_sel);

  always_comb
  begin
    if (scaled > 12'(`ERR_MAX))
      err_code = `ERR_MAX;
    else if (scaled < -12'sh020)
      err_code = `ERR_MIN;
    else
      err_code = scaled[5:0];
  end

  // ----------------------------------------
  // Set-point and saturation slew
  // ----------------------------------------
  logic signed [5:0] err_r;
  logic sat_r;
  logic [15:0] slew_cnt_r;
  logic slew_tick;

  assign slew_tick = (slew_cnt_r == 16'(`SLEW_CYC - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slew_cnt_r <= 16'h0000;
    else if (!sat_r || slew_tick)
      slew_cnt_r <= 16'h0000;
    else
      slew_cnt_r <= slew_cnt_r + 16'h0001;
  end

  // Software write wins over a slew step in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vref_r <= `RST_VREF;
    else if (wr_en && paddr == `OFF_VREF)
      vref_r <= wmerge[9:0];
    else if (sat_r && slew_tick)
    begin
      if (err_r == `ERR_MAX && vref_r != 10'h000)
        vref_r <= vref_r - 10'h001;
      else if (err_r == `ERR_MIN && vref_r != 10'h3ff)
        vref_r <= vref_r + 10'h001;
    end
  end

  // ----------------------------------------
  // Compensator sequence
  // ----------------------------------------
  calc_state_t state_r;
  logic signed [15:0] x_r;
  logic signed [15:0] x1_r;
  logic signed [15:0] x2_r;
  logic signed [15:0] y_r;
  logic signed [15:0] y1_r;
  logic signed [15:0] z_r;
  logic [15:0] duty_a_r;
  logic signed [5:0] lim [0:3];
  logic [`NLG_W-1:0] gsel;
  logic signed [15:0] x_nxt;
  logic signed [35:0] acc2;
  logic signed [35:0] acc1;
  logic signed [15:0] z_nxt;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      lim[i] = limits_r[i*8 +: 6];
    if (err_r < lim[0])
      gsel = nlgain_r[0 +: `NLG_W];
    else if (err_r < lim[1])
      gsel = nlgain_r[`NLG_W +: `NLG_W];
    else if (err_r <= lim[2])
      gsel = nlgain_r[2*`NLG_W +: `NLG_W];
    else if (err_r <= lim[3])
      gsel = nlgain_r[3*`NLG_W +: `NLG_W];
    else
      gsel = nlgain_r[4*`NLG_W +: `NLG_W];
  end

  assign x_nxt = 16'(err_r * $signed({1'b0, gsel}));
  assign acc2 = 36'(cb.b0 * x_r) + 36'(cb.b1 * x1_r) +
                36'(cb.b2 * x2_r) - 36'(cb.a1 * y_r) -
                36'(cb.a2 * y1_r);
  assign acc1 = 36'(cb.b3 * y_r) + 36'(cb.b4 * y1_r) -
                36'(cb.a3 * z_r);
  assign z_nxt = sat16(acc1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= CALC_IDLE;
    else
    begin
      case (state_r)
        CALC_IDLE:
          if (sample_pulse)
            state_r <= CALC_GAIN;
        CALC_GAIN: state_r <= CALC_SECOND;
        CALC_SECOND: state_r <= CALC_FIRST;
        CALC_FIRST: state_r <= CALC_IDLE;
        default: state_r <= CALC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_r <= 6'sh00;
      sat_r <= 1'b0;
    end
    else if (state_r == CALC_IDLE && sample_pulse)
    begin
      err_r <= err_code;
      sat_r <= (err_code == `ERR_MAX) || (err_code == `ERR_MIN);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      x_r <= 16'sh0000;
      x1_r <= 16'sh0000;
      x2_r <= 16'sh0000;
      y_r <= 16'sh0000;
      y1_r <= 16'sh0000;
      z_r <= 16'sh0000;
      duty_a_r <= 16'h0000;
    end
    else
    begin
      case (state_r)
        CALC_GAIN:
        begin
          x2_r <= x1_r;
          x1_r <= x_r;
          x_r <= x_nxt;
        end
        CALC_SECOND:
        begin
          y1_r <= y_r;
          y_r <= sat16(acc2);
        end
        CALC_FIRST:
        begin
          z_r <= z_nxt;
          // Negative effort clamps to zero duty
          duty_a_r <= z_nxt[15] ? 16'h0000 : {z_nxt[14:0], 1'b0};
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Pulse width engines and sync routing
  // ----------------------------------------
  pwm_cfg_t cfg_a;
  pwm_cfg_t cfg_b;
  logic start_a;
  logic start_b;
  logic [3:0] vec_a;
  logic [3:0] vec_b;
  logic so_r;

  assign cfg_a = '{en: ctrl_r[`CTRL_EN], period: period_r,
                   sync_sel: sync_r[`SYNC_A_LSB +: 2]};
  assign cfg_b = '{en: ctrl_r[`CTRL_EN], period: period_r,
                   sync_sel: sync_r[`SYNC_B_LSB +: 2]};
  // Own start masked: self-select runs free
  assign vec_a = {ext_edge, start_b, 2'h0};
  assign vec_b = {ext_edge, 1'b0, start_a, 1'b0};

  pulse_width_engine u_engine_a (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_a),
    .duty(duty_a_r),
    .sync_vec(vec_a),
    .gate_out(gate_drive_a),
    .period_start(start_a),
    .count(cnt_a)
  );

  pulse_width_engine u_engine_b (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg_b),
    .duty(duty_b_r),
    .sync_vec(vec_b),
    .gate_out(gate_drive_b),
    .period_start(start_b),
    .count()
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      so_r <= 1'b0;
    else
      so_r <= ctrl_r[`CTRL_SO_EN] &&
              (ctrl_r[`CTRL_SO_SRC] ? start_b : start_a);
  end

  assign ext_sync_output = so_r;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      `OFF_CTRL: prdata = ctrl_r;
      `OFF_SAMPLE: prdata = {16'h0000, sample_r};
      `OFF_PERIOD: prdata = {16'h0000, period_r};
      `OFF_SYNC: prdata = {28'h0000000, sync_r};
      `OFF_VREF: prdata = {22'h000000, vref_r};
      `OFF_LIMITS: prdata = limits_r;
      `OFF_NLGAIN: prdata = nlgain_r;
      `OFF_DUTYB: prdata = {16'h0000, duty_b_r};
      `OFF_STATUS:
      begin
        prdata[5:0] = err_r;
        prdata[`ST_SAT] = sat_r;
        prdata[`ST_BANK_LSB +: 2] = bank_sel;
        prdata[`ST_DUTY_LSB +: 16] = duty_a_r;
      end
      default:
        if (bank_hit)
          prdata = bank_w_r[bank_idx][word_idx];
    endcase
  end

endmodule // buck_loop_compensator_pwm

// file: buck_loop_regs.svh
// Register offsets, field positions, reset values and timing constants
`ifndef BUCK_LOOP_REGS_SVH
`define BUCK_LOOP_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFF_CTRL 12'h000
`define OFF_SAMPLE 12'h004
`define OFF_PERIOD 12'h008
`define OFF_SYNC 12'h00c
`define OFF_VREF 12'h010
`define OFF_LIMITS 12'h014
`define OFF_NLGAIN 12'h018
`define OFF_DUTYB 12'h01c
`define OFF_STATUS 12'h020
`define OFF_BANK_BASE 12'h040
`define OFF_BANK_END 12'h0a0
`define BANK_SHIFT 5
`define BANK_WORDS 3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_EN 0
`define CTRL_RAMP 1
`define CTRL_LIGHT 2
`define CTRL_SO_SRC 4
`define CTRL_SO_EN 5
`define SYNC_A_LSB 0
`define SYNC_B_LSB 2
`define ST_SAT 6
`define ST_BANK_LSB 8
`define ST_DUTY_LSB 16

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define BANK_RAMP 2'h0
`define BANK_REG 2'h1
`define BANK_LIGHT 2'h2
`define GAIN_8X 2'h3
`define ERR_MAX 6'sh1f
`define ERR_MIN 6'sh20
`define RST_PERIOD 16'h00c8
`define RST_SAMPLE 16'h00b4
`define RST_VREF 10'h000
`define RST_LIMITS 32'h0804fcf8
`define NLG_UNITY 6'h10
`define NLG_W 6
`define COEF_FRAC 14

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCLK_NS 5
`define VREF_LSB_UV 1000
`define SLEW_MV_PER_MS 156
`define SLEW_STEP_NS ((`VREF_LSB_UV * 1000000) / (`SLEW_MV_PER_MS * 1000))
`define SLEW_CYC (`SLEW_STEP_NS / `PCLK_NS)

`endif

// file: buck_loop_pkg.sv
// Shared types of the buck loop compensator and its pulse width engines
package buck_loop_pkg;

  typedef struct packed {
    logic signed [15:0] b0;
    logic signed [15:0] b1;
    logic signed [15:0] b2;
    logic signed [15:0] a1;
    logic signed [15:0] a2;
    logic signed [15:0] b3;
    logic signed [15:0] b4;
    logic signed [15:0] a3;
    logic [1:0] front_end_gain_sel;
  } coeff_bank_t;

  typedef struct packed {
    logic en;
    logic [15:0] period;
    logic [1:0] sync_sel;
  } pwm_cfg_t;

  typedef enum logic [1:0] {
    CALC_IDLE,
    CALC_GAIN,
    CALC_SECOND,
    CALC_FIRST
  } calc_state_t;

endpackage

// file: pulse_width_engine.sv
// Counter-compare pulse width engine with selectable ramp restart
`timescale 1ns/1ps
`include "buck_loop_regs.svh"

module pulse_width_engine
  import buck_loop_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pwm_cfg_t cfg,
  input wire logic [15:0] duty,
  input wire logic [3:0] sync_vec,
  output logic gate_out,
  output logic period_start,
  output logic [15:0] count
);

  logic [15:0] cnt_r;
  logic [15:0] thr_r;
  logic gate_r;
  logic start_r;
  logic wrap;
  logic sync_hit;
  logic restart;
  logic [31:0] prod;

  assign wrap = (cnt_r >= cfg.period - 16'h0001);
  // Code 0 selects free running, so bit 0 of sync_vec is never used
  assign sync_hit = (cfg.sync_sel != 2'h0) && sync_vec[cfg.sync_sel];
  assign restart = wrap || sync_hit;
  assign prod = duty * cfg.period;

  // ----------------------------------------
  // Ramp counter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 16'h0000;
    else if (!cfg.en || restart)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_r + 16'h0001;
  end

  // Threshold is shadowed so a pulse never sees a torn update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      thr_r <= 16'h0000;
    else if (restart)
      thr_r <= prod[31:16];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_r <= 1'b0;
    else
      gate_r <= cfg.en && (cnt_r < thr_r);
  end

  // Registered so engines syncing to each other form no loop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_r <= 1'b0;
    else
      start_r <= cfg.en && restart;
  end

  assign gate_out = gate_r;
  assign period_start = start_r;
  assign count = cnt_r;

endmodule // pulse_width_engine

// file: buck_loop_monitor.sv
// Port-level checks of the buck loop controller
`timescale 1ns/1ps
`include "buck_loop_regs.svh"

module buck_loop_monitor
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic gate_drive_a,
  input wire logic gate_drive_b,
  input wire logic ext_sync_output
);
  // ------------------------------
  // Helpers and properties
  // ------------------------------
  logic [5:0] ctrl_r;
  logic acc;
  logic rd_st;
  logic rd_vref;
  logic rd_lim;
  logic rd_gain;
  assign acc = psel && penable && pready;
  assign rd_st = acc && !pwrite && paddr == `OFF_STATUS;
  assign rd_vref = acc && !pwrite && paddr == `OFF_VREF;
  assign rd_lim = acc && !pwrite && paddr == `OFF_LIMITS;
  assign rd_gain = acc && !pwrite && (paddr == 12'h050 ||
                   paddr == 12'h070 || paddr == 12'h090);

  // Shadow of the control bits, so gate checks know the enables
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_r <= 6'h00;
    else if (acc && pwrite && pstrb[0] && paddr == `OFF_CTRL)
      ctrl_r <= pwdata[5:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_slverr; acc && pslverr |-> prdata == 32'h0; endproperty
  a_slverr: assert property (p_slverr) else $error("refused read data");
  property p_sat;
    rd_st |-> prdata[6] == (prdata[5:0] == 6'h1f || prdata[5:0] == 6'h20);
  endproperty
  a_sat: assert property (p_sat) else $error("saturation flag");
  property p_bank; rd_st |-> prdata[9:8] != 2'h3; endproperty
  a_bank: assert property (p_bank) else $error("bank code");
  property p_vref; rd_vref |-> prdata[31:10] == 22'h0; endproperty
  a_vref: assert property (p_vref) else $error("set-point width");
  property p_lim;
    rd_lim |-> ((prdata ^ (prdata << 1)) & 32'hc0c0c0c0) == 32'h0;
  endproperty
  a_lim: assert property (p_lim) else $error("limit fields");
  property p_gain; rd_gain |-> prdata[31:2] == 30'h0; endproperty
  a_gain: assert property (p_gain) else $error("bank gain field");
  property p_off;
    !ctrl_r[0] ##1 !ctrl_r[0] ##1 !ctrl_r[0] |-> !gate_drive_a && !gate_drive_b;
  endproperty
  a_off: assert property (p_off) else $error("gate while disabled");
  property p_pulse; ext_sync_output |=> !ext_sync_output; endproperty
  a_pulse: assert property (p_pulse) else $error("sync out width");
  property p_so_off;
    !ctrl_r[5] ##1 !ctrl_r[5] ##1 !ctrl_r[5] |-> !ext_sync_output;
  endproperty
  a_so_off: assert property (p_so_off) else $error("sync out off");
endmodule // buck_loop_monitor

bind buck_loop_compensator_pwm buck_loop_monitor #(.ADDR_W(ADDR_W)) u_mon
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gate_drive_a(gate_drive_a), .gate_drive_b(gate_drive_b),
  .ext_sync_output(ext_sync_output)
);

// file: buck_stage_model.sv
// Power stage and sense network beside the loop controller
`timescale 1ns/1ps

module buck_stage_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic gate,
  input wire logic [9:0] vout_mv,
  input wire logic sync_req,
  output logic [9:0] sense_pos_in,
  output logic [9:0] sense_neg_in,
  output logic ext_sync_input,
  output logic [15:0] on_cnt
);
  // ------------------------------
  // Sense lag and gate on-time
  // ------------------------------
  // Return line sits at ground, so the error rides on the positive leg
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sense_pos_in <= 10'h000;
      sense_neg_in <= 10'h000;
      ext_sync_input <= 1'b0;
      on_cnt <= 16'h0000;
    end
    else
    begin
      sense_pos_in <= vout_mv;
      sense_neg_in <= 10'h000;
      ext_sync_input <= sync_req;
      on_cnt <= on_cnt + {15'h0000, gate};
    end
endmodule // buck_stage_model

// file: test_buck_loop_compensator_pwm.sv
// Self-checking bench of the buck loop controller
`timescale 1ns/1ps
`include "buck_loop_regs.svh"

module test_buck_loop_compensator_pwm;
  // ------------------------------
  // Signals, models and tasks
  // ------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [9:0] vout_mv = 10'h000;
  logic sync_req = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] sense_pos_in;
  logic [9:0] sense_neg_in;
  logic ext_sync_input;
  logic gate_drive_a;
  logic gate_drive_b;
  logic ext_sync_output;
  logic [15:0] on_cnt;
  logic [31:0] q;
  logic e;
  int err_total = 0;
  int checked = 0;

  buck_loop_compensator_pwm #(.ADDR_W(12)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_pos_in(sense_pos_in), .sense_neg_in(sense_neg_in),
    .ext_sync_input(ext_sync_input), .gate_drive_a(gate_drive_a),
    .gate_drive_b(gate_drive_b), .ext_sync_output(ext_sync_output)
  );
  buck_stage_model u_stage
  (
    .pclk(pclk), .presetn(presetn), .gate(gate_drive_a),
    .vout_mv(vout_mv), .sync_req(sync_req), .sense_pos_in(sense_pos_in),
    .sense_neg_in(sense_neg_in), .ext_sync_input(ext_sync_input),
    .on_cnt(on_cnt)
  );

  initial
    forever #2.5 pclk = ~pclk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // No wait bound; the watchdog catches a stuck slave
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic t_reset;
    logic [11:0] a [8];
    logic [31:0] x [8];
    a = '{`OFF_CTRL, `OFF_SAMPLE, `OFF_PERIOD, `OFF_SYNC,
          `OFF_VREF, `OFF_LIMITS, `OFF_NLGAIN, `OFF_DUTYB};
    x = '{32'h0, 32'hb4, 32'hc8, 32'h0,
          32'h0, 32'h0804fcf8, 32'h10410410, 32'h0};
    for (int i = 0; i < 8; i++)
    begin
      rd(a[i]);
      chk("reset value", q, x[i]);
    end
    rd(12'h0fc);
    chk("unmapped", {e, q[30:0]}, 32'h80000000);
    rd(12'h006);
    chk("misaligned", {e, q[30:0]}, 32'h80000000);
  endtask

  task automatic t_setup;
    wr(`OFF_PERIOD, 32'h64);
    apb(1'b1, `OFF_PERIOD, 32'hff64, 4'h1);
    rd(`OFF_PERIOD);
    chk("strobe merge", q, 32'h64);
    wr(`OFF_SAMPLE, 32'h32);
    wr(`OFF_VREF, 32'h1f4);
    wr(12'h070, 32'h2);
    vout_mv <= 10'h1f4;
    wr(`OFF_CTRL, 32'h1);
  endtask

  task automatic t_gain;
    int x;
    for (int g = 0; g < 8; g++)
    begin
      vout_mv <= g[2] ? 10'h204 : 10'h1e4;
      wr(12'h070, 32'(g % 4));
      cyc(250);
      rd(`OFF_STATUS);
      x = (g[2] ? -16 : 16) >>> (3 - g % 4);
      chk("error code", {26'h0, q[5:0]}, {26'h0, x[5:0]});
      chk("no saturation", {31'h0, q[6]}, 32'h0);
    end
  endtask

  task automatic t_sat;
    wr(12'h070, 32'h3);
    vout_mv <= 10'h190;
    cyc(250);
    rd(`OFF_STATUS);
    chk("sat high", {25'h0, q[6:0]}, 32'h5f);
    cyc(1200);
    rd(`OFF_VREF);
    chk("slew", {31'h0, q == 32'h1f3 || q == 32'h1f2}, 32'h1);
    vout_mv <= 10'h258;
    cyc(250);
    rd(`OFF_STATUS);
    chk("sat low", {25'h0, q[6:0]}, 32'h60);
    vout_mv <= 10'h1f4;
    cyc(250);
    wr(`OFF_VREF, 32'h1f4);
  endtask

  task automatic t_bank;
    logic [31:0] c [4];
    logic [1:0] b [4];
    logic [5:0] x [4];
    c = '{32'h3, 32'h5, 32'h7, 32'h1};
    b = '{2'h0, 2'h2, 2'h0, 2'h1};
    x = '{6'h02, 6'h04, 6'h02, 6'h10};
    wr(12'h050, 32'h0);
    wr(12'h090, 32'h1);
    vout_mv <= 10'h1e4;
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFF_CTRL, c[i]);
      cyc(250);
      rd(`OFF_STATUS);
      chk("bank", {30'h0, q[9:8]}, {30'h0, b[i]});
      chk("bank gain", {26'h0, q[5:0]}, {26'h0, x[i]});
    end
  endtask

  task automatic t_pwm;
    logic [15:0] d [3];
    int n;
    logic [15:0] o;
    d = '{16'h8000, 16'hffff, 16'h0000};
    o = on_cnt;
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFF_DUTYB, {16'h0, d[i]});
      cyc(250);
      n = 0;
      repeat (100) @(negedge pclk) n += gate_drive_b;
      chk("width b", n, (d[i] * 100) >> 16);
    end
    chk("width a", {16'h0, on_cnt - o}, 32'h0);
  endtask

  task automatic t_nl;
    wr(12'h060, 32'h00004000);
    wr(12'h068, 32'h40000000);
    wr(`OFF_NLGAIN, 32'h00410410);
    cyc(250);
    rd(`OFF_STATUS);
    chk("duty top gain zero", {16'h0, q[31:16]}, 32'h0);
    wr(`OFF_NLGAIN, 32'h10410410);
    cyc(250);
    rd(`OFF_STATUS);
    chk("duty unity", {31'h0, q[31:16] != 16'h0}, 32'h1);
    vout_mv <= 10'h204;
    cyc(250);
    rd(`OFF_STATUS);
    chk("duty clamp", {16'h0, q[31:16]}, 32'h0);
  endtask

  task automatic t_sync;
    int n;
    logic [31:0] s [4];
    s = '{32'hc, 32'h0, 32'h4, 32'h8};
    wr(`OFF_DUTYB, 32'h8000);
    for (int i = 0; i < 4; i++)
    begin
      wr(`OFF_SYNC, s[i]);
      cyc(120);
      @(negedge gate_drive_b);
      cyc(10);
      sync_req <= 1'b1;
      @(posedge pclk);
      sync_req <= 1'b0;
      n = 0;
      while (gate_drive_b !== 1'b1 && n < 30)
      begin
        @(negedge pclk);
        n++;
      end
      chk("sync restart", {31'h0, n < 13}, {31'h0, i == 0});
    end
    wr(`OFF_CTRL, 32'h31);
    n = 0;
    repeat (200) @(negedge pclk) n += ext_sync_output;
    chk("sync out", n, 32'h2);
    wr(`OFF_CTRL, 32'h1);
    cyc(3);
    n = 0;
    repeat (200) @(negedge pclk) n += ext_sync_output;
    chk("sync out off", n, 32'h0);
  endtask

  initial
  begin
    #100000;
    err_total++;
    finish_test;
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_setup;
    t_gain;
    t_sat;
    t_bank;
    t_pwm;
    t_nl;
    t_sync;
    finish_test;
  end
endmodule // test_buck_loop_compensator_pwm
